// ### common/type2_pkg.sv
// constants used by the command message handler
package type2_pkg;
    localparam int CMD_LEN = 8;
    localparam logic [2:0] LAST_BYTE = 3'h7;
    localparam logic [7:0] HDR_RSVD = 8'h00;
    localparam logic [3:0] HDR_AXIS = 4'h0;
    localparam logic [3:0] HDR_TYPE = 4'h2;
    localparam logic [7:0] OP_PARAM_WR = 8'h83;
    localparam logic [7:0] OP_PARAM_RD = 8'h84;
    localparam logic [7:0] OP_POS_RD = 8'h88;
    localparam logic [7:0] OP_AUX_RD = 8'h89;
    localparam logic [7:0] OP_UREG_WR = 8'h9e;
    localparam logic [7:0] OP_UREG_RD = 8'h9f;
    localparam logic [7:0] PARAM_ACCEL = 8'h1e;
    localparam logic [7:0] POS_ENC = 8'h00;
    localparam logic [7:0] POS_ABS = 8'h01;
    localparam logic [15:0] ACCEL_RST = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_RX = 2'b00,
        ST_CHECK = 2'b01,
        ST_LOAD = 2'b10,
        ST_TX = 2'b11
    } state_type;
endpackage

// ### rtl/user_reg_file.sv
// 32-bit user register store with a registered read port
`timescale 1ns/1ps
module user_reg_file #(
    parameter int DW = 32,
    parameter int AW = 6
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o
);
    logic [DW-1:0] mem [2**AW];

    // array left unreset so it maps onto block memory
    always_ff @(posedge mclk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rd_data_o <= '0;
        end else if (rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule // user_reg_file

// ### rtl/type2_message_handler.sv
// command message handler: parses eight-byte commands and builds echo responses
//
// Summary of operation
// - byte 2 is the opcode, byte 3 the operand; together they pick the action.
// - response bytes 2 and 3 echo the command opcode and operand.
// - response byte 0 is zero, byte 1 holds axis 0 and type 2.
// - non-read commands answer status word in bytes 4-5, zero in 6-7.
// - status word is a bit pattern reporting fault, motion and similar.
// - readback only via these commands; 16 or 32 bits replace status.
// - command data is 16 bits in bytes 4-5 except for opcode 0x9e.
// - opcode 0x9e carries 32-bit data in bytes 4-7, msb first.
// - opcode 0x9f returns a 32-bit value in bytes 4-7, msb first.
// - opcode 0x83 writes 16-bit data to operand's parameter, answers status.
// - opcode 0x84 returns the parameter in bytes 4-5, zero in 6-7.
// - operand 0x1e selects acceleration rate in units of 10 rpm/s.
// - opcode 0x88 operand 1 returns 32-bit absolute position, msb first.
// - opcodes 0x84, 0x88, 0x89 place read data from byte 4 on.
// - opcode 0x88 operand 0 returns 32-bit encoder position, msb first.
// - user register operand is a register code selecting a 32-bit register.
`timescale 1ns/1ps
module type2_message_handler #(
    parameter int REG_AW = 6,
    parameter logic [15:0] ACCEL_RST = type2_pkg::ACCEL_RST
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_byte_i,
    output logic cmd_ready_o,
    output logic resp_valid_o,
    output logic [7:0] resp_byte_o,
    output logic resp_last_o,
    input wire logic resp_ready_i,
    input wire logic [15:0] status_word_i,
    input wire logic [31:0] abs_pos_i,
    input wire logic [31:0] enc_pos_i,
    input wire logic [15:0] aux_word_i,
    output logic [15:0] accel_rate_cmd_o,
    output logic accel_wr_o,
    output logic hdr_err_o
);
    type2_pkg::state_type state;
    logic [2:0] cnt;
    logic [63:0] cmd_q;
    logic [63:0] resp_q;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [15:0] data16;
    logic [31:0] data32;
    logic hdr_ok;
    logic ureg_wr;
    logic ureg_rd;
    logic [31:0] ureg_data;
    logic [31:0] next_payload;

    assign opcode = cmd_q[47:40];
    assign operand = cmd_q[39:32];
    assign data16 = cmd_q[31:16];
    assign data32 = cmd_q[31:0];
    assign hdr_ok = (cmd_q[63:56] == type2_pkg::HDR_RSVD)
        && (cmd_q[55:48] == {type2_pkg::HDR_AXIS, type2_pkg::HDR_TYPE});

    assign cmd_ready_o = (state == type2_pkg::ST_RX);
    assign resp_valid_o = (state == type2_pkg::ST_TX);
    assign resp_byte_o = resp_q[63:56];
    assign resp_last_o = resp_valid_o && (cnt == type2_pkg::LAST_BYTE);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state <= type2_pkg::ST_RX;
        end else begin
            case (state)
                type2_pkg::ST_RX: begin
                    if (cmd_valid_i && cnt == type2_pkg::LAST_BYTE) begin
                        state <= type2_pkg::ST_CHECK;
                    end
                end
                type2_pkg::ST_CHECK: begin
                    // a bad header is consumed without an answer, only hdr_err_o pulses, so framing stays aligned
                    state <= hdr_ok ? type2_pkg::ST_LOAD : type2_pkg::ST_RX;
                end
                type2_pkg::ST_LOAD: begin
                    state <= type2_pkg::ST_TX;
                end
                type2_pkg::ST_TX: begin
                    if (resp_ready_i && cnt == type2_pkg::LAST_BYTE) begin
                        state <= type2_pkg::ST_RX;
                    end
                end
                default: begin
                    state <= type2_pkg::ST_RX;
                end
            endcase
        end
    end

    // one byte counter serves both directions; they never overlap
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cnt <= '0;
        end else if ((state == type2_pkg::ST_RX && cmd_valid_i)
                     || (state == type2_pkg::ST_TX && resp_ready_i)) begin
            cnt <= cnt + 3'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cmd_q <= '0;
        end else if (state == type2_pkg::ST_RX && cmd_valid_i) begin
            cmd_q <= {cmd_q[55:0], cmd_byte_i};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            hdr_err_o <= 1'b0;
        end else begin
            hdr_err_o <= (state == type2_pkg::ST_CHECK) && !hdr_ok;
        end
    end

    // acceleration rate, 10 rpm/s per count
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            accel_rate_cmd_o <= ACCEL_RST;
            accel_wr_o <= 1'b0;
        end else begin
            accel_wr_o <= 1'b0;
            if (state == type2_pkg::ST_CHECK && hdr_ok && opcode == type2_pkg::OP_PARAM_WR
                && operand == type2_pkg::PARAM_ACCEL) begin
                accel_rate_cmd_o <= data16;
                accel_wr_o <= 1'b1;
            end
        end
    end

    assign ureg_wr = (state == type2_pkg::ST_CHECK) && hdr_ok
        && (opcode == type2_pkg::OP_UREG_WR);
    assign ureg_rd = (state == type2_pkg::ST_CHECK) && hdr_ok
        && (opcode == type2_pkg::OP_UREG_RD);

    user_reg_file #(
        .DW(32),
        .AW(REG_AW)
    ) u_regs (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .wr_en_i(ureg_wr),
        .wr_addr_i(operand[REG_AW-1:0]),
        .wr_data_i(data32),
        .rd_en_i(ureg_rd),
        .rd_addr_i(operand[REG_AW-1:0]),
        .rd_data_o(ureg_data)
    );

    always_comb begin
        case (opcode)
            type2_pkg::OP_PARAM_RD: begin
                // unknown parameters read back as zero
                next_payload = (operand == type2_pkg::PARAM_ACCEL)
                    ? {accel_rate_cmd_o, type2_pkg::ZERO16}
                    : type2_pkg::ZERO32;
            end
            type2_pkg::OP_POS_RD: begin
                if (operand == type2_pkg::POS_ENC) begin
                    next_payload = enc_pos_i;
                end else if (operand == type2_pkg::POS_ABS) begin
                    next_payload = abs_pos_i;
                end else begin
                    next_payload = type2_pkg::ZERO32;
                end
            end
            type2_pkg::OP_AUX_RD: begin
                next_payload = {aux_word_i, type2_pkg::ZERO16};
            end
            type2_pkg::OP_UREG_RD: begin
                next_payload = ureg_data;
            end
            default: begin
                next_payload = {status_word_i, type2_pkg::ZERO16};
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            resp_q <= '0;
        end else if (state == type2_pkg::ST_LOAD) begin
            resp_q <= {type2_pkg::HDR_RSVD, type2_pkg::HDR_AXIS, type2_pkg::HDR_TYPE,
                       opcode, operand, next_payload};
        end else if (state == type2_pkg::ST_TX && resp_ready_i) begin
            resp_q <= {resp_q[55:0], 8'h00};
        end
    end

    logic status_op;
    assign status_op = (opcode != type2_pkg::OP_PARAM_RD) && (opcode != type2_pkg::OP_POS_RD)
        && (opcode != type2_pkg::OP_AUX_RD) && (opcode != type2_pkg::OP_UREG_RD);

    property p_hdr_drop;
        @(posedge mclk_i) disable iff (srst_i)
        (state == type2_pkg::ST_CHECK && !hdr_ok) |=> (state == type2_pkg::ST_RX) && hdr_err_o;
    endproperty
    a_hdr_drop: assert property (p_hdr_drop) else $error("bad header not dropped");

    property p_one_resp;
        @(posedge mclk_i) disable iff (srst_i)
        (state == type2_pkg::ST_CHECK && hdr_ok) |=> (state == type2_pkg::ST_LOAD)
            ##1 resp_valid_o[*8];
    endproperty
    a_one_resp: assert property (p_one_resp) else $error("response not started");

    property p_header;
        @(posedge mclk_i) disable iff (srst_i)
        (state == type2_pkg::ST_LOAD) |=> resp_q[63:48] == 16'h0002;
    endproperty
    a_header: assert property (p_header) else $error("response header wrong");

    property p_echo;
        @(posedge mclk_i) disable iff (srst_i)
        (state == type2_pkg::ST_LOAD) |=> resp_q[47:32] == $past(cmd_q[47:32]);
    endproperty
    a_echo: assert property (p_echo) else $error("opcode or operand not echoed");

    property p_status;
        @(posedge mclk_i) disable iff (srst_i)
        (state == type2_pkg::ST_LOAD && status_op)
            |=> resp_q[31:0] == {$past(status_word_i), 16'h0000};
    endproperty
    a_status: assert property (p_status) else $error("status word missing");

    property p_accel_wr;
        @(posedge mclk_i) disable iff (srst_i)
        (state == type2_pkg::ST_CHECK && hdr_ok && opcode == 8'h83 && operand == 8'h1e)
            |=> accel_rate_cmd_o == $past(cmd_q[31:16]) && accel_wr_o;
    endproperty
    a_accel_wr: assert property (p_accel_wr) else $error("parameter write lost");

    property p_param_rd;
        @(posedge mclk_i) disable iff (srst_i)
        (state == type2_pkg::ST_LOAD && opcode == 8'h84 && operand == 8'h1e)
            |=> resp_q[31:0] == {$past(accel_rate_cmd_o), 16'h0000};
    endproperty
    a_param_rd: assert property (p_param_rd) else $error("parameter read wrong");

    property p_enc;
        @(posedge mclk_i) disable iff (srst_i)
        (state == type2_pkg::ST_LOAD && opcode == 8'h88 && operand == 8'h00)
            |=> resp_q[31:0] == $past(enc_pos_i);
    endproperty
    a_enc: assert property (p_enc) else $error("encoder position wrong");

    // position sits in bytes 4..7 of the shift register, msb first
    property p_abs;
        @(posedge mclk_i) disable iff (srst_i)
        (state == type2_pkg::ST_LOAD && opcode == 8'h88 && operand == 8'h01)
            |=> resp_q[31:0] == $past(abs_pos_i);
    endproperty
    a_abs: assert property (p_abs) else $error("absolute position wrong");

    property p_tx_end;
        @(posedge mclk_i) disable iff (srst_i)
        (resp_last_o && resp_ready_i) |=> cmd_ready_o && !resp_valid_o;
    endproperty
    a_tx_end: assert property (p_tx_end) else $error("response longer than 8 bytes");
endmodule // type2_message_handler

// ### tb/host_model.sv
// host controller model: sends commands, collects responses
`timescale 1ns/1ps
module host_model (
    input wire logic mclk_i,
    input wire logic cmd_ready_i,
    input wire logic resp_valid_i,
    input wire logic [7:0] resp_byte_i,
    input wire logic resp_last_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_byte_o,
    output logic resp_ready_o
);
    int tmo = 0;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_byte_o = 8'hff;
        resp_ready_o = 1'b0;
    end
    // byte 0 first, data msb first, each byte held until taken
    task automatic send(input logic [63:0] m);
        int n;
        for (int i = 0; i < 8; i++) begin
            cmd_valid_o <= 1'b1;
            cmd_byte_o <= m[63-8*i -: 8];
            n = 0;
            @(posedge mclk_i);
            while (cmd_ready_i !== 1'b1 && n < 100) begin
                n++;
                @(posedge mclk_i);
            end
            if (n == 100) tmo++;
        end
        // idle bus shows the inverse so a stale byte never looks valid
        cmd_valid_o <= 1'b0;
        cmd_byte_o <= ~m[7:0];
    endtask
    // stall holds ready low that many cycles before each byte
    task automatic recv(output logic [63:0] m, output logic [7:0] lst, input int stall);
        int n;
        for (int i = 0; i < 8; i++) begin
            repeat (stall) @(posedge mclk_i);
            resp_ready_o <= 1'b1;
            n = 0;
            @(posedge mclk_i);
            while (resp_valid_i !== 1'b1 && n < 100) begin
                n++;
                @(posedge mclk_i);
            end
            if (n == 100) tmo++;
            m[63-8*i -: 8] = resp_byte_i;
            lst[7-i] = resp_last_i;
            if (stall != 0 || i == 7) resp_ready_o <= 1'b0;
        end
    endtask
endmodule // host_model

// ### tb/type2_message_handler_tb.sv
// self-checking bench for the command message handler
`timescale 1ns/1ps
module type2_message_handler_tb;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic cmd_valid, cmd_ready, resp_valid, resp_last, resp_ready, accel_wr, hdr_err;
    logic [7:0] cmd_byte, resp_byte;
    logic [15:0] status = 16'ha5c3;
    logic [15:0] aux = 16'h0f1e;
    logic [31:0] abs_pos = 32'h8765_4321;
    logic [31:0] enc_pos = 32'h1234_5678;
    logic [15:0] accel;
    int err_total = 0;
    int n_compared = 0;
    int n_wr = 0;
    int n_hdr = 0;
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    type2_message_handler uut (.mclk_i(mclk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid),
        .cmd_byte_i(cmd_byte), .cmd_ready_o(cmd_ready), .resp_valid_o(resp_valid),
        .resp_byte_o(resp_byte), .resp_last_o(resp_last), .resp_ready_i(resp_ready),
        .status_word_i(status), .abs_pos_i(abs_pos), .enc_pos_i(enc_pos),
        .aux_word_i(aux), .accel_rate_cmd_o(accel), .accel_wr_o(accel_wr),
        .hdr_err_o(hdr_err));
    host_model host (.mclk_i(mclk_i), .cmd_ready_i(cmd_ready), .resp_valid_i(resp_valid),
        .resp_byte_i(resp_byte), .resp_last_i(resp_last), .cmd_valid_o(cmd_valid),
        .cmd_byte_o(cmd_byte), .resp_ready_o(resp_ready));
    always @(posedge mclk_i) begin
        if (accel_wr === 1'b1) n_wr++;
        if (hdr_err === 1'b1) n_hdr++;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        err_total = err_total + host.tmo;
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one whole command and its answer, compared byte for byte
    task automatic xact(input logic [7:0] op, opd, input logic [31:0] d, pl, input int stall);
        logic [63:0] r;
        logic [7:0] l;
        host.send({8'h00, 8'h02, op, opd, d});
        host.recv(r, l, stall);
        if (host.tmo != 0) test_done();
        check(r, {8'h00, 8'h02, op, opd, pl});
        check(l, 8'h01);
    endtask
    task t_reset;
        srst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        check({cmd_ready, resp_valid, resp_last, resp_byte, accel}, {3'b100, 8'h00, 16'h0000});
    endtask
    task t_param;
        xact(8'h83, 8'h1e, 32'h0258_0000, {status, 16'h0000}, 0);
        check(accel, 16'h0258);
        check(n_wr, 1);
        xact(8'h84, 8'h1e, 32'h0, 32'h0258_0000, 3);
        // unknown parameter reads back as zero
        xact(8'h84, 8'h05, 32'h0, 32'h0, 0);
        status <= 16'h0081;
        // unknown parameter: answered with status, accel untouched
        xact(8'h83, 8'h05, 32'h1111_0000, 32'h0081_0000, 0);
        check({n_wr, accel}, {32'd1, 16'h0258});
    endtask
    task t_pos;
        xact(8'h88, 8'h01, 32'h0, abs_pos, 0);
        xact(8'h88, 8'h00, 32'h0, enc_pos, 2);
        // position source other than encoder or absolute reads back as zero
        xact(8'h88, 8'h02, 32'h0, 32'h0, 1);
        xact(8'h89, 8'h00, 32'h0, {aux, 16'h0000}, 0);
    endtask
    task t_ureg;
        xact(8'h9e, 8'h33, 32'hc0de_0133, {status, 16'h0000}, 0);
        xact(8'h9e, 8'h34, 32'h1e2d_3c4b, {status, 16'h0000}, 1);
        xact(8'h9f, 8'h33, 32'h0, 32'hc0de_0133, 0);
        xact(8'h9f, 8'h34, 32'h0, 32'h1e2d_3c4b, 2);
    endtask
    // bad reserved byte, then bad axis: both dropped without answer
    task automatic t_bad;
        int seen;
        seen = 0;
        for (int k = 0; k < 2; k++) begin
            host.send(k == 0 ? 64'h0102_8400_0000_0000 : 64'h0012_8400_0000_0000);
            repeat (20) begin
                @(posedge mclk_i);
                if (resp_valid === 1'b1) seen++;
            end
        end
        check(seen, 0);
        check(n_hdr, 2);
        xact(8'h84, 8'h1e, 32'h0, 32'h0258_0000, 0);
    endtask
    // second command is offered while the first answer is still stalled
    task automatic t_b2b;
        logic [63:0] r;
        logic [7:0] l;
        host.send(64'h0002_8801_0000_0000);
        @(posedge mclk_i);
        fork
            host.send(64'h0002_8800_0000_0000);
            host.recv(r, l, 4);
        join
        check(r, {32'h0002_8801, abs_pos});
        @(posedge mclk_i);
        host.recv(r, l, 0);
        check(r, {32'h0002_8800, enc_pos});
    endtask
    initial begin
        t_reset();
        t_param();
        t_pos();
        t_ureg();
        t_bad();
        t_b2b();
        t_reset();
        test_done();
    end
endmodule // type2_message_handler_tb
